// >>> swd_core.sv
/*
 * Switch detect and wake control core: input interpretation, interrupt
 * and wake pin handling, Normal/Sleep mode, and the serial slave port.
 * Assumes rst_b is the battery power-on reset, the serial clock idles low
 * whenever chip select moves, and chip select leads the first clock by
 * well over five mclk periods.
 */
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Normal mode: enabled switch change pulls interrupt output low.
// - Chip select fall captures interrupt state and flag for the response.
// - Only the device that raised an interrupt reports its flag set.
// - Chip select rise releases interrupt unless a change came while low.
// - Sleep, wake high, supply present: interrupt line fall wakes device.
// - Wake pin pulled low in Normal mode, released in Sleep mode.
// - Sleep: wake pin fall wakes; needs interrupt high only with supply.
// - Battery power-on resets all state and starts in Normal mode.
// - No logic supply: serial refused, no wake from select or interrupt.
// - Programmable input closed above threshold if battery-type, below if ground.
// - Ground inputs closed below threshold, open above.
// - A transaction is twenty-four bit clocks with chip select low.
// - Every response carries switch states, interrupt and thermal flags.
// - Switch states sampled into output register at chip select fall.
// - Losing logic supply in Normal mode keeps Normal mode.
// - Losing logic supply in Sleep keeps Sleep until wake, switch or timer.
// - Reset loads battery-type, wake on, high current, timer on, tri-state, mux zero.
// - Temperature monitor, thus thermal flag, works only in Normal mode.
// - Input sampled on falling clock edges, output shifted on rising.
// - Command and response move MSB first through one FIFO path.
// - Command acts only at chip select rise.
module swd_core
   import swd_pkg::*;
(
   input  wire logic                   mclk,          // System clock
   input  wire logic                   rst_b,         // Battery power-on reset
   input  wire logic                   sclk,          // Serial bit clock
   input  wire logic                   cs_b,          // Chip select pin
   input  wire logic                   si,            // Serial data in
   output var  logic                   so,            // Serial data out
   output var  logic                   so_oe_b,       // Low while driving so
   input  wire logic                   int_in,        // Shared interrupt line level
   output var  logic                   int_out,       // Interrupt drive value
   output var  logic                   int_oe_b,      // Low while pulling line
   input  wire logic                   wake_in,       // Wake line level
   output var  logic                   wake_out,      // Wake drive value
   output var  logic                   wake_oe_b,     // Low while pulling line
   input  wire logic                   logic_supply,  // Logic supply present
   input  wire logic [swd_pkg::N_SP-1:0] programmable_switch_inputs, // Above ref
   input  wire logic [swd_pkg::N_SG-1:0] ground_switch_inputs,       // Above ref
   input  wire logic                   thermal_in,    // Over-temperature sense
   input  wire logic                   int_timer_exp, // Interrupt timer expired
   output var  swd_pkg::swd_cfg_t      cfg,           // Active configuration
   output var  swd_pkg::swd_stat_t     status,        // Live switch status
   output var  logic                   normal_mode    // 1: Normal, 0: Sleep
);
   import swd_pkg::*;

   // ==========================================================
   // Input synchronisers (three flops, change on agreement)
   // ==========================================================
   localparam int NS = N_SP + N_SG + 7;
   // Select pin and interrupt line idle high, so no false edge after reset
   localparam logic [NS-1:0] SYNC_IDLE = {2'b11, {(NS-2){1'b0}}};

   logic [NS-1:0] async_in;
   logic [NS-1:0] s1_r;
   logic [NS-1:0] s2_r;
   logic [NS-1:0] s3_r;
   logic [NS-1:0] flt_r;
   logic [NS-1:0] flt_d_r;
   logic          tgl_r;

   assign async_in = {cs_b, int_in, wake_in, logic_supply, thermal_in,
                      int_timer_exp, tgl_r,
                      programmable_switch_inputs, ground_switch_inputs};

   genvar gi;
   generate
      for (gi = 0; gi < NS; gi++) begin : g_sync
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               s1_r[gi]    <= SYNC_IDLE[gi];
               s2_r[gi]    <= SYNC_IDLE[gi];
               s3_r[gi]    <= SYNC_IDLE[gi];
               flt_r[gi]   <= SYNC_IDLE[gi];
               flt_d_r[gi] <= SYNC_IDLE[gi];
            end else begin
               s1_r[gi]    <= async_in[gi];
               s2_r[gi]    <= s1_r[gi];
               s3_r[gi]    <= s2_r[gi];
               flt_d_r[gi] <= flt_r[gi];
               if (s2_r[gi] == s3_r[gi]) begin
                  flt_r[gi] <= s3_r[gi];
               end
            end
         end
      end
   endgenerate

   logic            cs_f;
   logic            int_f;
   logic            wake_f;
   logic            vdd_f;
   logic            therm_f;
   logic            tgl_f;
   logic [N_SP-1:0] sp_f;
   logic [N_SG-1:0] sg_f;
   logic            cs_fall;
   logic            cs_rise;
   logic            int_fall;
   logic            wake_fall;
   logic            tmr_rise;

   assign {cs_f, int_f, wake_f, vdd_f, therm_f} = flt_r[NS-1 -: 5];
   assign tgl_f     = flt_r[N_SW];
   assign sp_f      = flt_r[N_SW-1:N_SG];
   assign sg_f      = flt_r[N_SG-1:0];
   assign cs_fall   = flt_d_r[NS-1] & ~cs_f;
   assign cs_rise   = ~flt_d_r[NS-1] & cs_f;
   assign int_fall  = flt_d_r[NS-2] & ~int_f;
   assign wake_fall = flt_d_r[NS-3] & ~wake_f;
   assign tmr_rise  = ~flt_d_r[NS-6] & flt_r[NS-6];

   // ==========================================================
   // Switch interpretation
   // ==========================================================
   swd_cfg_t        cfg_r;
   logic            normal_r;
   logic [N_SP-1:0] sp_closed;
   logic [N_SG-1:0] sg_closed;
   logic [N_SW-1:0] sw_now;
   logic [N_SW-1:0] sw_prev_r;
   logic            sw_change;

   assign sp_closed = ~(sp_f ^ cfg_r.sp_batt);
   assign sg_closed = ~sg_f;
   assign sw_now    = {sg_closed, sp_closed};
   assign sw_change = |((sw_now ^ sw_prev_r) & cfg_r.wake_en);

   // Previous state resets to all-closed-free; first compare after reset
   // may flag a change, which is the safe side for an interrupt line.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sw_prev_r <= '0;
      end else begin
         sw_prev_r <= sw_now;
      end
   end

   // ==========================================================
   // Mode control
   // ==========================================================
   logic       cmd_go;
   logic [7:0] cmd_op;
   logic       wake_evt;

   assign wake_evt = sw_change
                   | tmr_rise
                   | (wake_fall & (int_f | ~vdd_f))
                   | (int_fall & vdd_f & wake_f)
                   | (cs_fall & vdd_f);

   // Supply loss alone never changes the mode
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         normal_r <= 1'b1;
      end else if (!normal_r) begin
         if (wake_evt) begin
            normal_r <= 1'b1;
         end
      end else if (cmd_go && cmd_op == OP_SLEEP) begin
         normal_r <= 1'b0;
      end
   end

   assign wake_out    = 1'b0;
   assign wake_oe_b   = ~normal_r;
   assign normal_mode = normal_r;

   // ==========================================================
   // Interrupt output
   // ==========================================================
   logic int_act_r;
   logic chg_in_cs_r;
   logic cs_low_r;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cs_low_r <= 1'b0;
      end else if (cs_fall) begin
         cs_low_r <= 1'b1;
      end else if (cs_rise) begin
         cs_low_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         chg_in_cs_r <= 1'b0;
      end else if (cs_fall) begin
         chg_in_cs_r <= 1'b0;
      end else if (cs_low_r && sw_change) begin
         chg_in_cs_r <= 1'b1;
      end
   end

   // A change in the same cycle as the release keeps the line low
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         int_act_r <= 1'b0;
      end else if (sw_change && (normal_r || wake_evt)) begin
         int_act_r <= 1'b1;
      end else if (cs_rise && !chg_in_cs_r) begin
         int_act_r <= 1'b0;
      end
   end

   assign int_out  = 1'b0;
   assign int_oe_b = ~int_act_r;

   // ==========================================================
   // Response snapshot
   // ==========================================================
   swd_stat_t live;
   swd_stat_t snap_r;

   assign live.int_flag   = int_act_r;
   assign live.therm_flag = therm_f & normal_r;
   assign live.sp_closed  = sp_closed;
   assign live.sg_closed  = sg_closed;
   assign status          = live;

   // Word is held steady from here until the next chip select fall,
   // so the serial side may read it without its own synchroniser.
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         snap_r <= '0;
      end else if (cs_fall) begin
         snap_r <= live;
      end
   end

   // ==========================================================
   // Serial link (bit clock domain)
   // ==========================================================
   logic [FRAME_BITS-1:0] rx_r;
   logic [CNT_W-1:0]      fcnt_r;
   logic [CNT_W-1:0]      rcnt_r;
   logic                  so_r;
   logic                  link_rst;

   // Bit counters also clear at power-on, never left unknown
   assign link_rst = cs_b | ~rst_b;

   always_ff @(negedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_r <= '0;
      end else if (!cs_b) begin
         rx_r <= {rx_r[FRAME_BITS-2:0], si};
      end
   end

   always_ff @(negedge sclk or posedge link_rst) begin
      if (link_rst) begin
         fcnt_r <= '0;
      end else if (fcnt_r != FRAME_FULL) begin
         fcnt_r <= fcnt_r + 1'b1;
      end
   end

   // One flip per frame marks that a full word arrived
   always_ff @(negedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         tgl_r <= 1'b0;
      end else if (!cs_b && fcnt_r == FRAME_LAST) begin
         tgl_r <= ~tgl_r;
      end
   end

   always_ff @(posedge sclk or posedge link_rst) begin
      if (link_rst) begin
         rcnt_r <= '0;
         so_r   <= 1'b0;
      end else begin
         if (rcnt_r != FRAME_FULL) begin
            rcnt_r <= rcnt_r + 1'b1;
            so_r   <= snap_r[FRAME_BITS-1-rcnt_r];
         end else begin
            so_r   <= rx_r[FRAME_BITS-1];
         end
      end
   end

   assign so      = so_r;
   assign so_oe_b = cs_b | ~vdd_f;

   // ==========================================================
   // Command capture and configuration
   // ==========================================================
   logic                  tgl_seen_r;
   logic [FRAME_BITS-1:0] cmd_w;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tgl_seen_r <= 1'b0;
      end else if (cs_rise) begin
         tgl_seen_r <= tgl_f;
      end
   end

   // Bit clock is stopped by now, so the received word is quiet
   assign cmd_w  = rx_r;
   assign cmd_op = cmd_w[OP_MSB:OP_LSB];
   assign cmd_go = cs_rise && (tgl_f != tgl_seen_r)
                && vdd_f && normal_r;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r <= CFG_DEFAULT;
      end else if (cmd_go) begin
         unique case (cmd_op)
            OP_SETTINGS: cfg_r.sp_batt                 <= cmd_w[N_SP-1:0];
            OP_WAKE_SP:  cfg_r.wake_en[N_SP-1:0]       <= cmd_w[N_SP-1:0];
            OP_WAKE_SG:  cfg_r.wake_en[N_SW-1:N_SP]    <= cmd_w[N_SG-1:0];
            OP_MET_SP:   cfg_r.metallic[N_SP-1:0]      <= cmd_w[N_SP-1:0];
            OP_MET_SG:   cfg_r.metallic[N_SW-1:N_SP]   <= cmd_w[N_SG-1:0];
            OP_TMR_SP:   cfg_r.wtimer_en[N_SP-1:0]     <= cmd_w[N_SP-1:0];
            OP_TMR_SG:   cfg_r.wtimer_en[N_SW-1:N_SP]  <= cmd_w[N_SG-1:0];
            OP_TRI_SP:   cfg_r.tristate[N_SP-1:0]      <= cmd_w[N_SP-1:0];
            OP_TRI_SG:   cfg_r.tristate[N_SW-1:N_SP]   <= cmd_w[N_SG-1:0];
            OP_ANALOG:   cfg_r.amux_sel                <= cmd_w[AMUX_W-1:0];
            OP_RESET:    cfg_r                         <= CFG_DEFAULT;
            default:     cfg_r                         <= cfg_r;
         endcase
      end
   end

   assign cfg = cfg_r;

endmodule : swd_core

`default_nettype wire

// >>> swd_pkg.sv
/*
 * Shared constants and types for the switch detect / wake control block:
 * frame layout, command codes, power-on defaults and carrier structs.
 * Assumes a 24-bit serial frame with an 8-bit command code in the top byte.
 */
`default_nettype none

package swd_pkg;

   // ==========================================================
   // Sizes
   // ==========================================================
   localparam int N_SP       = 8;
   localparam int N_SG       = 14;
   localparam int N_SW       = N_SP + N_SG;
   localparam int FRAME_BITS = 24;
   localparam int CNT_W      = 5;
   localparam int AMUX_W     = 5;
   localparam int OP_MSB     = 23;
   localparam int OP_LSB     = 16;
   localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_BITS - 1);
   localparam logic [CNT_W-1:0] FRAME_FULL = CNT_W'(FRAME_BITS);

   // ==========================================================
   // Command codes
   // ==========================================================
   localparam logic [7:0] OP_SETTINGS = 8'h01;
   localparam logic [7:0] OP_WAKE_SP  = 8'h02;
   localparam logic [7:0] OP_WAKE_SG  = 8'h03;
   localparam logic [7:0] OP_MET_SP   = 8'h04;
   localparam logic [7:0] OP_MET_SG   = 8'h05;
   localparam logic [7:0] OP_TMR_SP   = 8'h07;
   localparam logic [7:0] OP_TMR_SG   = 8'h08;
   localparam logic [7:0] OP_TRI_SP   = 8'h09;
   localparam logic [7:0] OP_TRI_SG   = 8'h0A;
   localparam logic [7:0] OP_ANALOG   = 8'h0B;
   localparam logic [7:0] OP_SLEEP    = 8'h0C;
   localparam logic [7:0] OP_RESET    = 8'h0D;

   // ==========================================================
   // Power-on / reset-command defaults
   // ==========================================================
   localparam logic [N_SP-1:0]   DEF_SP_BATT = 8'hFF;
   localparam logic [N_SW-1:0]   DEF_ALL_ON  = 22'h3F_FFFF;
   localparam logic [AMUX_W-1:0] DEF_AMUX    = 5'h00;

   // ==========================================================
   // Carriers
   // ==========================================================
   typedef struct packed {
      logic [N_SP-1:0]   sp_batt;     // 1: switch to battery
      logic [N_SW-1:0]   wake_en;     // {sg, sp}
      logic [N_SW-1:0]   metallic;    // 1: high wetting current
      logic [N_SW-1:0]   wtimer_en;   // wetting timer enable
      logic [N_SW-1:0]   tristate;    // 1: input high impedance
      logic [AMUX_W-1:0] amux_sel;
   } swd_cfg_t;

   typedef struct packed {
      logic            int_flag;
      logic            therm_flag;
      logic [N_SP-1:0] sp_closed;
      logic [N_SG-1:0] sg_closed;
   } swd_stat_t;

   localparam swd_cfg_t CFG_DEFAULT = '{
      sp_batt:   DEF_SP_BATT,
      wake_en:   DEF_ALL_ON,
      metallic:  DEF_ALL_ON,
      wtimer_en: DEF_ALL_ON,
      tristate:  DEF_ALL_ON,
      amux_sel:  DEF_AMUX
   };

endpackage : swd_pkg

`default_nettype wire

// >>> swd_core_assertions.sv
/*
 * Checker for swd_core: interrupt, wake pin, serial enable, status, config.
 * Assumes it is bound to swd_core and sees only that module's ports.
 */
`timescale 1ns/100ps
`default_nettype none
module swd_core_chk
   import swd_pkg::*;
(
   input wire logic                   mclk,
   input wire logic                   rst_b,
   input wire logic                   cs_b,
   input wire logic                   so_oe_b,
   input wire logic                   int_oe_b,
   input wire logic                   wake_oe_b,
   input wire logic                   logic_supply,
   input wire logic [N_SP-1:0]        programmable_switch_inputs,
   input wire logic [N_SG-1:0]        ground_switch_inputs,
   input wire swd_pkg::swd_cfg_t      cfg,
   input wire swd_pkg::swd_stat_t     status,
   input wire logic                   normal_mode
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ===========================================================
   // Sequences
   // ===========================================================
   sequence sw_event;
      normal_mode && cfg.wake_en == DEF_ALL_ON
         && $changed({programmable_switch_inputs, ground_switch_inputs});
   endsequence
   // Long enough for the input synchronisers to catch up
   sequence inputs_settled;
      ($stable({programmable_switch_inputs, ground_switch_inputs}) && $stable(cfg.sp_batt))[*8];
   endsequence
   // ===========================================================
   // Properties
   // ===========================================================
   a_int_on_change: assert property (sw_event |-> ##[1:8] !int_oe_b)
      else $error("interrupt not raised after switch change");
   a_int_held_low: assert property (!cs_b && !int_oe_b |=> !int_oe_b)
      else $error("interrupt released while selected");
   a_wake_pin_normal: assert property (normal_mode && $past(normal_mode) |-> !wake_oe_b)
      else $error("wake pin not pulled in normal mode");
   a_wake_pin_sleep: assert property (!normal_mode && !$past(normal_mode) |-> wake_oe_b)
      else $error("wake pin pulled in sleep mode");
   a_so_idle_off: assert property (cs_b |-> so_oe_b)
      else $error("serial output driven while deselected");
   a_so_sel_on: assert property ((!cs_b && logic_supply)[*6] |-> !so_oe_b)
      else $error("serial output not driven while selected");
   a_so_no_supply: assert property ((!logic_supply)[*5] |-> so_oe_b)
      else $error("serial output driven without supply");
   a_reset_state: assert property ($rose(rst_b) |-> normal_mode && cfg == CFG_DEFAULT)
      else $error("wrong state after power-on reset");
   a_cfg_frame_hold: assert property ((!cs_b)[*8] |-> $stable(cfg))
      else $error("configuration changed during a frame");
   a_sg_status: assert property (inputs_settled |-> status.sg_closed == ~ground_switch_inputs)
      else $error("ground input status wrong");
   a_sp_status: assert property (inputs_settled
      |-> status.sp_closed == ~(programmable_switch_inputs ^ cfg.sp_batt))
      else $error("programmable input status wrong");
   a_therm_sleep: assert property (!normal_mode && !$past(normal_mode) |-> !status.therm_flag)
      else $error("thermal flag set in sleep");
endmodule : swd_core_chk
bind swd_core swd_core_chk u_swd_core_chk (.mclk(mclk), .rst_b(rst_b), .cs_b(cs_b),
   .so_oe_b(so_oe_b), .int_oe_b(int_oe_b), .wake_oe_b(wake_oe_b), .logic_supply(logic_supply),
   .programmable_switch_inputs(programmable_switch_inputs),
   .ground_switch_inputs(ground_switch_inputs), .cfg(cfg), .status(status),
   .normal_mode(normal_mode));
`default_nettype wire

// >>> swd_host.sv
/*
 * Behavioural serial host: drives chip select, bit clock and data in.
 * Assumes the bench resolves the released data-out line.
 */
`timescale 1ns/100ps
`default_nettype none
module swd_host (
   output var  logic sclk,    // Bit clock, still between frames
   output var  logic cs_b,    // Chip select
   output var  logic si,      // Data to device
   input  wire logic so_line  // Resolved data-out line
);
   localparam int HALF_NS = 24; // 48 ns period, under the maximum rate
   initial begin
      sclk = 1'b0;
      si   = 1'b0;
      #1 cs_b = 1'b1; // After time zero, so the link reset edge is seen
   end
   task automatic xfer(input logic [47:0] cmd, input int nbits, output logic [47:0] resp);
      resp = '0;
      #7 cs_b = 1'b0; // Odd offset keeps phase unrelated to mclk
      #120;
      for (int i = nbits - 1; i >= 0; i--) begin
         sclk = 1'b1;
         si   = cmd[i];
         #(HALF_NS);
         resp = {resp[46:0], so_line};
         sclk = 1'b0;
         #(HALF_NS);
      end
      #60 cs_b = 1'b1;
      si = ~si;
      #200;
   endtask : xfer
endmodule : swd_host
`default_nettype wire

// >>> tb_top.sv
/*
 * Self-checking bench for swd_core with a behavioural serial host.
 * Assumes the package constants and a 100 MHz system clock.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import swd_pkg::*;
   logic mclk, rst_b, sclk, cs_b, si, so, so_oe_b, int_out, int_oe_b, wake_out, wake_oe_b;
   logic logic_supply, thermal_in, int_timer_exp, normal_mode, int_pull, wake_pull;
   logic [N_SP-1:0] sp_in;
   logic [N_SG-1:0] sg_in;
   swd_cfg_t cfg;
   swd_stat_t status;
   logic [47:0] resp;
   int mismatches, n_compared, cycles;
   wire so_line   = so_oe_b ? ~so : so;        // Released line shows no stale value
   wire int_line  = !(!int_oe_b || int_pull);  // Pull-up
   wire wake_line = !(!wake_oe_b || wake_pull);
   swd_core u_swd_core (.mclk(mclk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .si(si), .so(so),
      .so_oe_b(so_oe_b), .int_in(int_line), .int_out(int_out), .int_oe_b(int_oe_b),
      .wake_in(wake_line), .wake_out(wake_out), .wake_oe_b(wake_oe_b),
      .logic_supply(logic_supply), .programmable_switch_inputs(sp_in),
      .ground_switch_inputs(sg_in), .thermal_in(thermal_in), .int_timer_exp(int_timer_exp),
      .cfg(cfg), .status(status), .normal_mode(normal_mode));
   swd_host u_swd_host (.sclk(sclk), .cs_b(cs_b), .si(si), .so_line(so_line));
   // ===========================================================
   // Helpers
   // ===========================================================
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end
   task automatic wclk(input int n);
      repeat (n) @(negedge mclk);
   endtask : wclk
   task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask : chk
   task automatic frame(input logic [23:0] cmd);
      u_swd_host.xfer({24'h0000_00, cmd}, 24, resp);
      wclk(10);
   endtask : frame
   task automatic results();
      $display("checks %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   // ===========================================================
   // Scenarios
   // ===========================================================
   task automatic t_reset();
      chk("cfg", 1'b1, cfg === CFG_DEFAULT);
      chk("drive", 2'b00, {int_out, wake_out});
      chk("normal", 1'b1, normal_mode);
      chk("wake_oe_b", 1'b0, wake_oe_b);
   endtask : t_reset
   task automatic t_status();
      sp_in = 8'hA5;
      sg_in = 14'h1C3A;
      thermal_in = 1'b1;
      wclk(10);
      frame(24'h0000_00);
      chk("resp", {2'b11, 8'hA5, ~14'h1C3A}, resp[23:0]);
      chk("int_oe_b", 1'b1, int_oe_b);
      thermal_in = 1'b0;
   endtask : t_status
   task automatic t_config();
      frame({OP_SETTINGS, 16'h000F});
      chk("sp_batt", 8'h0F, cfg.sp_batt);
      frame(24'h0000_00);
      chk("sp_closed", 8'h55, resp[21:14]);
      u_swd_host.xfer({24'h0000_00, OP_ANALOG, 16'h0003}, 23, resp);
      wclk(10);
      chk("amux short", 5'h00, cfg.amux_sel);
      u_swd_host.xfer({24'hA5_5A3C, OP_ANALOG, 16'h0007}, 48, resp);
      wclk(10);
      chk("passed on", 24'hA5_5A3C, resp[23:0]);
      chk("amux chain", 5'h07, cfg.amux_sel);
      frame({OP_WAKE_SP, 16'h005A});
      frame({OP_MET_SP, 16'h0033});
      frame({OP_MET_SG, 16'h1234});
      frame({OP_TMR_SP, 16'h00C3});
      frame({OP_TMR_SG, 16'h2A0F});
      frame({OP_TRI_SP, 16'h0081});
      frame({OP_TRI_SG, 16'h0F0F});
      chk("cfg sp", 32'h5A33_C381, {cfg.wake_en[7:0], cfg.metallic[7:0],
          cfg.wtimer_en[7:0], cfg.tristate[7:0]});
      chk("cfg sg", {14'h1234, 14'h2A0F, 14'h0F0F}, {cfg.metallic[21:8],
          cfg.wtimer_en[21:8], cfg.tristate[21:8]});
      frame({OP_RESET, 16'h0000});
      chk("cfg reset", 1'b1, cfg === CFG_DEFAULT);
   endtask : t_config
   task automatic t_interrupt();
      frame(24'h0000_00);
      sg_in[0] = ~sg_in[0];
      wclk(10);
      chk("int raised", 1'b0, int_oe_b);
      chk("int live", 1'b1, status.int_flag);
      frame(24'h0000_00);
      chk("int flag", 1'b1, resp[23]);
      chk("int cleared", 1'b1, int_oe_b);
      fork
         frame(24'h0000_00);
         begin
            #600 @(negedge mclk) sg_in[0] = ~sg_in[0];
         end
      join
      chk("int kept", 1'b0, int_oe_b);
      frame(24'h0000_00);
      frame({OP_WAKE_SG, 16'h0000});
      sg_in[0] = ~sg_in[0];
      wclk(10);
      chk("int masked", 1'b1, int_oe_b);
      frame(24'h0000_00);
      chk("flag masked", 1'b0, resp[23]);
      frame({OP_RESET, 16'h0000});
   endtask : t_interrupt
   task automatic t_sleep();
      frame({OP_SLEEP, 16'h0000});
      thermal_in = 1'b1;
      wclk(8);
      chk("sleep", 2'b01, {normal_mode, wake_oe_b});
      chk("therm sleep", 1'b0, status.therm_flag);
      thermal_in = 1'b0;
      wake_pull = 1'b1;
      wclk(10);
      chk("wake pin", 1'b1, normal_mode);
      wake_pull = 1'b0;
      frame({OP_SLEEP, 16'h0000});
      logic_supply = 1'b0;
      wclk(6);
      frame(24'h0000_00);
      int_pull = 1'b1;
      wclk(10);
      chk("no supply", 1'b0, normal_mode);
      wake_pull = 1'b1;
      wclk(10);
      chk("wake no vdd", 1'b1, normal_mode);
      {wake_pull, int_pull, logic_supply} = 3'b001;
      wclk(6);
      frame({OP_SLEEP, 16'h0000});
      int_pull = 1'b1;
      wclk(10);
      chk("int wake", 1'b1, normal_mode);
      int_pull = 1'b0;
      logic_supply = 1'b0;
      wclk(10);
      chk("keep normal", 1'b1, normal_mode);
      logic_supply = 1'b1;
      wclk(6);
      frame({OP_SLEEP, 16'h0000});
      logic_supply = 1'b0;
      int_timer_exp = 1'b1;
      wclk(10);
      chk("timer wake", 1'b1, normal_mode);
      {int_timer_exp, logic_supply} = 2'b01;
   endtask : t_sleep
   initial begin
      {mismatches, n_compared, cycles} = '0;
      {int_pull, wake_pull, thermal_in, int_timer_exp} = '0;
      logic_supply = 1'b1;
      sp_in = 8'h00;
      sg_in = 14'h3FFF;
      #1 rst_b = 1'b0; // After time zero, so every reset edge is seen
      wclk(12);
      rst_b = 1'b1;
      wclk(10);
      t_reset();
      t_status();
      t_config();
      t_interrupt();
      t_sleep();
      results();
   end
endmodule : tb_top
`default_nettype wire
